// ==== rtl/usb_port_pkg.sv ====
// Shared constants of the FIFO port configuration block.
// Assumes a 16-bit register file reached over a 32-bit APB bus.
package usb_port_pkg;
  // ==========================================================
  // Widths
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int ADDR_LSB = 2;
  localparam int REG_W = 16;
  localparam int IDX_W = APB_AW - ADDR_LSB;
  localparam int BYTE_W = 8;
  localparam int PIPE_W = 3;
  localparam int NUM_PIPES = 7;
  localparam int GP_W = 8;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_CFG = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_CPORT_CTRL = 10'h02e;
  localparam logic [IDX_W-1:0] IDX_EMPTY_EN = 10'h04c;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h050;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h052;
  localparam logic [IDX_W-1:0] IDX_PIPE_SEL = 10'h054;
  localparam logic [IDX_W-1:0] IDX_PIPE_DIR = 10'h056;
  localparam logic [IDX_W-1:0] IDX_PIPE_CONT = 10'h058;
  localparam logic [IDX_W-1:0] IDX_GP_OUT = 10'h05a;
  localparam logic [IDX_W-1:0] IDX_GP_IN = 10'h05c;
  localparam logic [IDX_W-1:0] IDX_CPORT_DATA = 10'h05e;
  localparam logic [IDX_W-1:0] IDX_DPORT_DATA = 10'h062;
  // ==========================================================
  // Reset values, masks and fields
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PIN_CFG_WMASK = 16'h8105;
  localparam logic [REG_W-1:0] EMPTY_EN_WMASK = 16'h007f;
  localparam int PIN_SPLIT_BIT = 0;
  localparam int PIN_GP_DIR_BIT = 2;
  localparam int PIN_BIG_END_BIT = 8;
  localparam int PIN_DRIVE_BIT = 15;
  localparam int CTRL_SWAP_BIT = 15;
  localparam int CTRL_CLEAR_BIT = 14;
  localparam int CTRL_BUSY_BIT = 13;
  localparam logic [PIPE_W-1:0] CTRL_PIPE = 3'h0;
  localparam int IRQ_BUF_READY = 0;
  localparam int IRQ_EMPTY_SUM = 1;
  localparam int NUM_IRQ = 2;
endpackage

// ==== rtl/reg_bus_if.sv ====
// Internal register strobes between the APB port and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface reg_bus_if;
  import usb_port_pkg::*;
  logic wr;
  logic rd;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic hit;
  modport port (output wr, rd, idx, wdata, input rdata, hit);
  modport regs (input wr, rd, idx, wdata, output rdata, hit);
endinterface

// ==== rtl/apb_reg_port.sv ====
// APB slave front end: one wait-free access phase, registered read data.
// Assumes a compliant APB master and a combinational read mux behind it.
`timescale 1ns/100ps
module apb_reg_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usb_port_pkg::APB_AW-1:0] paddr,
  input wire logic [usb_port_pkg::APB_DW-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [usb_port_pkg::APB_DW-1:0] prdata,
  // Register side
  reg_bus_if.port bus
);
  import usb_port_pkg::*;

  logic [REG_W-1:0] rdata_ff;
  logic err_ff;
  logic setup;

  assign setup = psel & ~penable;
  assign bus.idx = paddr[APB_AW-1:ADDR_LSB];
  assign bus.wdata = pwdata[REG_W-1:0];
  assign bus.wr = psel & penable & pwrite;
  assign bus.rd = psel & penable & ~pwrite;
  assign pready = psel & penable;
  assign pslverr = pready & err_ff;
  assign prdata = {{(APB_DW-REG_W){1'b0}}, rdata_ff};

  // Read data sampled in setup so prdata comes from a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= REG_RESET;
      err_ff <= 1'b0;
    end else if (setup) begin
      rdata_ff <= pwrite ? REG_RESET : bus.rdata;
      err_ff <= ~bus.hit;
    end
  end
endmodule

// ==== rtl/irq_status.sv ====
// Sticky interrupt status with write-one-to-clear and a mask.
// Assumes event inputs are one-cycle or level requests on clk.
`timescale 1ns/100ps
module irq_status #(
  parameter int N = usb_port_pkg::NUM_IRQ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sw_reset,
  // Events and register writes
  input wire logic [N-1:0] event_set,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status_ff,
  output logic [N-1:0] mask_ff,
  output logic irq
);
  import usb_port_pkg::*;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= '0;
    end else if (sw_reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~({N{status_wr}} & wdata)) | event_set;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= '0;
    end else if (sw_reset) begin
      mask_ff <= '0;
    end else if (mask_wr) begin
      mask_ff <= wdata;
    end
  end

  assign irq = |(status_ff & mask_ff);
endmodule

// ==== rtl/usb_fifo_port_config.sv ====
// Pin function, FIFO port byte order and control port buffer control.
// Assumes the serial engine gives per-pipe busy and empty levels on clk.
//
// Summary of operation
// [RQ1] Byte order bit: 0 little, 1 big endian, for both FIFO ports.
// [RQ2] Function bit: 0 general port, 1 split bus for the DMA port.
// [RQ3] With split bus active, DMA port data accesses are ignored.
// [RQ4] Direction bit: 0 input, 1 output; only while general port.
// [RQ5] Reserved bits read zero; software writes them as zero.
// [RQ6] Swap write on OUT continuous pipe, FIFO not full, hands buffer.
// [RQ7] Accepted swap raises the buffer ready interrupt.
// [RQ8] Swap and clear ignored on default control pipe; busy invalid.
// [RQ9] Clear write on IN pipe empties engine buffer; reads as zero.
// [RQ10] Software never writes the clear bit on OUT pipes.
// [RQ11] Software sets NAK, waits busy low, then writes clear.
// [RQ12] Busy bit shows engine access to the selected pipe buffer.
// [RQ13] Per-pipe enable lets that pipe set the empty summary flag.
// [RQ14] Enabled pipe empty status sets the empty summary flag.
// [RQ15] Registers clear on hardware and software reset only.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module usb_fifo_port_config #(
  parameter int NUM_PIPES = usb_port_pkg::NUM_PIPES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sw_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usb_port_pkg::APB_AW-1:0] paddr,
  input wire logic [usb_port_pkg::APB_DW-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [usb_port_pkg::APB_DW-1:0] prdata,
  // Serial engine status
  input wire logic [NUM_PIPES-1:0] pipe_empty_status,
  input wire logic [NUM_PIPES-1:0] engine_busy,
  input wire logic fifo_full,
  // FIFO data paths
  input wire logic [usb_port_pkg::REG_W-1:0] cfifo_rdata,
  input wire logic [usb_port_pkg::REG_W-1:0] dfifo_rdata,
  output logic [usb_port_pkg::REG_W-1:0] fifo_wdata,
  output logic cfifo_wr,
  output logic cfifo_rd,
  output logic dfifo_wr,
  output logic dfifo_rd,
  // Buffer control
  output logic [usb_port_pkg::PIPE_W-1:0] current_pipe,
  output logic buffer_swap,
  output logic engine_buffer_clear,
  // Pin configuration
  output logic big_endian,
  output logic data_pins_function_select,
  output logic output_drive_select,
  // General port pins
  input wire logic [usb_port_pkg::GP_W-1:0] gp_port_pins_in,
  output logic [usb_port_pkg::GP_W-1:0] gp_port_pins_out,
  output logic [usb_port_pkg::GP_W-1:0] gp_port_pins_oe_n,
  // Interrupt
  output logic buffer_empty_summary_flag,
  output logic irq
);
  import usb_port_pkg::*;

  // ==========================================================
  // Declarations
  reg_bus_if bus ();
  logic [REG_W-1:0] pin_cfg_ff;
  logic [REG_W-1:0] empty_en_ff;
  logic [PIPE_W-1:0] pipe_sel_ff;
  logic [NUM_PIPES-1:0] pipe_dir_in_ff;
  logic [NUM_PIPES-1:0] pipe_cont_ff;
  logic [GP_W-1:0] gp_out_ff;
  logic [GP_W-1:0] gp_in_ff;
  logic [REG_W-1:0] fifo_wdata_ff;
  logic cfifo_wr_ff;
  logic cfifo_rd_ff;
  logic dfifo_wr_ff;
  logic dfifo_rd_ff;
  logic swap_ff;
  logic clear_ff;
  logic [NUM_IRQ-1:0] irq_status_ff;
  logic [NUM_IRQ-1:0] irq_mask_ff;
  logic [NUM_IRQ-1:0] irq_events;
  logic [NUM_PIPES-1:0] empty_hit;
  logic wr_ctrl;
  logic pipe_ok;
  logic sel_dir_in;
  logic sel_cont;
  logic sel_busy;
  logic swap_ok;
  logic clear_ok;
  logic split;
  logic dport_ok;

  function automatic logic [REG_W-1:0] order16(
    input logic [REG_W-1:0] d,
    input logic big
  );
    order16 = big ? {d[BYTE_W-1:0], d[REG_W-1:BYTE_W]} : d;
  endfunction

  // ==========================================================
  // Bus front end and interrupts
  apb_reg_port u_apb (
    .clk(clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .bus(bus.port)
  );

  irq_status #(.N(NUM_IRQ)) u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .sw_reset(sw_reset),
    .event_set(irq_events),
    .status_wr(bus.wr && bus.idx == IDX_IRQ_STATUS),
    .mask_wr(bus.wr && bus.idx == IDX_IRQ_MASK),
    .wdata(bus.wdata[NUM_IRQ-1:0]),
    .status_ff(irq_status_ff),
    .mask_ff(irq_mask_ff),
    .irq(irq)
  );

  // ==========================================================
  // Selected pipe decode
  assign split = pin_cfg_ff[PIN_SPLIT_BIT];
  assign pipe_ok = (pipe_sel_ff != CTRL_PIPE) &&
                   (32'(pipe_sel_ff) < NUM_PIPES);
  assign sel_dir_in = pipe_ok && pipe_dir_in_ff[pipe_sel_ff];
  assign sel_cont = pipe_ok && pipe_cont_ff[pipe_sel_ff];
  // [RQ12] Busy of selected pipe
  // [RQ8] Control pipe busy reads zero, its value is not meaningful
  assign sel_busy = pipe_ok && engine_busy[pipe_sel_ff];
  assign wr_ctrl = bus.wr && bus.idx == IDX_CPORT_CTRL;
  // [RQ6] Swap only OUT, continuous, not full
  // [RQ8] Control pipe blocks swap
  assign swap_ok = wr_ctrl && bus.wdata[CTRL_SWAP_BIT] && pipe_ok &&
                   !sel_dir_in && sel_cont && !fifo_full;
  // [RQ9] Clear only IN pipes
  // [RQ10] Clear on an OUT pipe is dropped, not acted on
  assign clear_ok = wr_ctrl && bus.wdata[CTRL_CLEAR_BIT] && sel_dir_in;
  // [RQ3] DMA port dead while split bus
  assign dport_ok = !split;

  // ==========================================================
  // Configuration registers
  // [RQ15] Hardware and software reset clear, no bus reset input
  // [RQ1] [RQ2] [RQ4] Pin config write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_cfg_ff <= REG_RESET;
    end else if (sw_reset) begin
      pin_cfg_ff <= REG_RESET;
    end else if (bus.wr && bus.idx == IDX_PIN_CFG) begin
      pin_cfg_ff <= bus.wdata & PIN_CFG_WMASK;
    end
  end

  // [RQ13] Per-pipe empty enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      empty_en_ff <= REG_RESET;
    end else if (sw_reset) begin
      empty_en_ff <= REG_RESET;
    end else if (bus.wr && bus.idx == IDX_EMPTY_EN) begin
      empty_en_ff <= bus.wdata & EMPTY_EN_WMASK;
    end
  end

  // Pipe selection and per-pipe modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pipe_sel_ff <= CTRL_PIPE;
      pipe_dir_in_ff <= '0;
      pipe_cont_ff <= '0;
    end else if (sw_reset) begin
      pipe_sel_ff <= CTRL_PIPE;
      pipe_dir_in_ff <= '0;
      pipe_cont_ff <= '0;
    end else if (bus.wr) begin
      if (bus.idx == IDX_PIPE_SEL) begin
        pipe_sel_ff <= bus.wdata[PIPE_W-1:0];
      end
      if (bus.idx == IDX_PIPE_DIR) begin
        pipe_dir_in_ff <= bus.wdata[NUM_PIPES-1:0];
      end
      if (bus.idx == IDX_PIPE_CONT) begin
        pipe_cont_ff <= bus.wdata[NUM_PIPES-1:0];
      end
    end
  end

  // General port output latch and input sampling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gp_out_ff <= '0;
      gp_in_ff <= '0;
    end else begin
      gp_in_ff <= gp_port_pins_in;
      if (sw_reset) begin
        gp_out_ff <= '0;
      end else if (bus.wr && bus.idx == IDX_GP_OUT) begin
        gp_out_ff <= bus.wdata[GP_W-1:0];
      end
    end
  end

  // ==========================================================
  // FIFO port strobes and buffer commands
  // [RQ1] Byte lanes reordered on write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_wdata_ff <= REG_RESET;
    end else if (bus.wr && (bus.idx == IDX_CPORT_DATA ||
                 (bus.idx == IDX_DPORT_DATA && dport_ok))) begin
      fifo_wdata_ff <= order16(bus.wdata, pin_cfg_ff[PIN_BIG_END_BIT]);
    end
  end

  // [RQ3] DMA port strobes gated by split bus
  // [RQ6] [RQ9] One-cycle buffer commands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfifo_wr_ff <= 1'b0;
      cfifo_rd_ff <= 1'b0;
      dfifo_wr_ff <= 1'b0;
      dfifo_rd_ff <= 1'b0;
      swap_ff <= 1'b0;
      clear_ff <= 1'b0;
    end else begin
      cfifo_wr_ff <= bus.wr && bus.idx == IDX_CPORT_DATA;
      cfifo_rd_ff <= bus.rd && bus.idx == IDX_CPORT_DATA;
      dfifo_wr_ff <= bus.wr && bus.idx == IDX_DPORT_DATA && dport_ok;
      dfifo_rd_ff <= bus.rd && bus.idx == IDX_DPORT_DATA && dport_ok;
      swap_ff <= swap_ok;
      clear_ff <= clear_ok;
    end
  end

  // ==========================================================
  // Interrupt events
  // [RQ13] [RQ14] Enabled empty status per pipe
  generate
    for (genvar i = 0; i < NUM_PIPES; i++) begin : g_empty
      assign empty_hit[i] = pipe_empty_status[i] & empty_en_ff[i];
    end
  endgenerate

  always_comb begin
    irq_events = '0;
    // [RQ7] Accepted swap is buffer ready
    irq_events[IRQ_BUF_READY] = swap_ff;
    // [RQ14] Summary flag set
    irq_events[IRQ_EMPTY_SUM] = |empty_hit;
  end

  // ==========================================================
  // Read mux
  // [RQ5] Reserved and write-only bits read as zero
  always_comb begin
    bus.rdata = REG_RESET;
    bus.hit = 1'b1;
    unique case (bus.idx)
      IDX_PIN_CFG: bus.rdata = pin_cfg_ff;
      IDX_CPORT_CTRL: bus.rdata[CTRL_BUSY_BIT] = sel_busy;
      IDX_EMPTY_EN: bus.rdata = empty_en_ff;
      IDX_IRQ_STATUS: bus.rdata[NUM_IRQ-1:0] = irq_status_ff;
      IDX_IRQ_MASK: bus.rdata[NUM_IRQ-1:0] = irq_mask_ff;
      IDX_PIPE_SEL: bus.rdata[PIPE_W-1:0] = pipe_sel_ff;
      IDX_PIPE_DIR: bus.rdata[NUM_PIPES-1:0] = pipe_dir_in_ff;
      IDX_PIPE_CONT: bus.rdata[NUM_PIPES-1:0] = pipe_cont_ff;
      IDX_GP_OUT: bus.rdata[GP_W-1:0] = gp_out_ff;
      IDX_GP_IN: bus.rdata[GP_W-1:0] = gp_in_ff;
      // [RQ1] Byte lanes reordered on read
      IDX_CPORT_DATA:
        bus.rdata = order16(cfifo_rdata, pin_cfg_ff[PIN_BIG_END_BIT]);
      // [RQ3] Split bus reads zero here
      IDX_DPORT_DATA: begin
        if (dport_ok) begin
          bus.rdata = order16(dfifo_rdata, pin_cfg_ff[PIN_BIG_END_BIT]);
        end
      end
      default: bus.hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Outputs
  assign fifo_wdata = fifo_wdata_ff;
  assign cfifo_wr = cfifo_wr_ff;
  assign cfifo_rd = cfifo_rd_ff;
  assign dfifo_wr = dfifo_wr_ff;
  assign dfifo_rd = dfifo_rd_ff;
  assign current_pipe = pipe_sel_ff;
  assign buffer_swap = swap_ff;
  assign engine_buffer_clear = clear_ff;
  assign big_endian = pin_cfg_ff[PIN_BIG_END_BIT];
  assign data_pins_function_select = split;
  assign output_drive_select = pin_cfg_ff[PIN_DRIVE_BIT];
  assign gp_port_pins_out = gp_out_ff;
  // [RQ4] Drive only as output general port
  assign gp_port_pins_oe_n =
    {GP_W{~(pin_cfg_ff[PIN_GP_DIR_BIT] & ~split)}};
  assign buffer_empty_summary_flag = irq_status_ff[IRQ_EMPTY_SUM];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence swap_req_s;
    wr_ctrl && bus.wdata[CTRL_SWAP_BIT];
  endsequence

  sequence swap_done_s;
    buffer_swap ##1 irq_status_ff[IRQ_BUF_READY];
  endsequence

  endian_write_a: assert property ( // [RQ1]
    bus.wr && bus.idx == IDX_CPORT_DATA |=> cfifo_wr &&
      fifo_wdata == order16($past(bus.wdata), $past(big_endian)))
    else $error("fifo write data byte order wrong");

  split_select_a: assert property ( // [RQ2]
    bus.wr && bus.idx == IDX_PIN_CFG && !sw_reset |=>
      data_pins_function_select == $past(bus.wdata[PIN_SPLIT_BIT]))
    else $error("pin function select did not follow write");

  dma_ignore_a: assert property ( // [RQ3]
    split && bus.idx == IDX_DPORT_DATA && (bus.wr || bus.rd) |=>
      !dfifo_wr && !dfifo_rd)
    else $error("dma port access taken during split bus");

  gp_drive_a: assert property ( // [RQ4]
    gp_port_pins_oe_n == '0 |->
      pin_cfg_ff[PIN_GP_DIR_BIT] && !data_pins_function_select)
    else $error("general port driven outside output mode");

  reserved_zero_a: assert property ( // [RQ5]
    bus.idx == IDX_PIN_CFG |-> (bus.rdata & ~PIN_CFG_WMASK) == '0)
    else $error("reserved pin config bits not zero");

  swap_pulse_a: assert property ( // [RQ6]
    swap_req_s ##0 (pipe_ok && !sel_dir_in && sel_cont && !fifo_full)
      |=> buffer_swap ##1 !buffer_swap)
    else $error("buffer swap not a single pulse");

  ready_irq_a: assert property ( // [RQ7]
    swap_req_s ##0 (swap_ok && !sw_reset) ##1 !sw_reset |-> swap_done_s)
    else $error("swap did not raise buffer ready");

  ctrl_pipe_a: assert property ( // [RQ8]
    wr_ctrl && pipe_sel_ff == CTRL_PIPE |=>
      !buffer_swap && !engine_buffer_clear)
    else $error("command acted on control pipe");

  clear_pulse_a: assert property ( // [RQ9]
    wr_ctrl && bus.wdata[CTRL_CLEAR_BIT] |=>
      engine_buffer_clear == $past(sel_dir_in))
    else $error("buffer clear decision wrong");

  busy_read_a: assert property ( // [RQ12]
    psel && !penable && !pwrite && bus.idx == IDX_CPORT_CTRL |=>
      prdata[CTRL_BUSY_BIT] == $past(sel_busy) &&
      prdata[CTRL_SWAP_BIT] == 1'b0)
    else $error("busy bit read back wrong");

  empty_block_a: assert property ( // [RQ13]
    $rose(buffer_empty_summary_flag) |-> $past(|empty_hit))
    else $error("summary flag set by disabled pipe");

  empty_set_a: assert property ( // [RQ14]
    |empty_hit && !sw_reset |=> buffer_empty_summary_flag)
    else $error("enabled empty status did not set flag");

  sw_reset_a: assert property ( // [RQ15]
    sw_reset |=> pin_cfg_ff == REG_RESET && empty_en_ff == REG_RESET)
    else $error("software reset left configuration set");
endmodule

// ==== tb/engine_model.sv ====
// Serial engine stand-in: per-pipe busy and empty levels, one full level.
// Assumes the bench steers it through the command inputs on clk.
`timescale 1ns/100ps
module engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic [6:0] busy_cmd,
  input wire logic [6:0] empty_cmd,
  input wire logic full_cmd,
  // Engine status and data
  output logic [6:0] pipe_empty_status,
  output logic [6:0] engine_busy,
  output logic fifo_full,
  output logic [15:0] cfifo_rdata,
  output logic [15:0] dfifo_rdata
);
  // Registered, so the block sees a real engine's one-cycle lag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      engine_busy <= 7'h00;
      pipe_empty_status <= 7'h00;
      fifo_full <= 1'b0;
    end else begin
      engine_busy <= busy_cmd;
      pipe_empty_status <= empty_cmd;
      fifo_full <= full_cmd;
    end
  end
  // Distinct bytes so a swapped order shows
  assign cfifo_rdata = 16'h1234;
  assign dfifo_rdata = 16'h5678;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the FIFO port configuration block.
// Assumes the APB port answers in the access cycle of each transfer.
`timescale 1ns/100ps
module tb_top;
  import usb_port_pkg::*;
  logic clk = 0, reset_n = 0, sw_reset = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, cwr, crd, dwr, drd, swp, clr;
  logic big, split, drv, flag, irq, full;
  logic [6:0] busy_cmd = 0, empty_cmd = 0, pes, eb;
  logic full_cmd = 0;
  logic [15:0] crdata, drdata, fwd, cap_wd;
  logic [2:0] cur;
  logic [7:0] gp_in = 8'h5a, gp_out, oe_n;
  int fail_count = 0, samples_checked = 0, swp_n = 0, clr_n = 0, dwr_n = 0;
  int crd_n = 0, drd_n = 0;

  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (swp === 1'b1) swp_n++;
    if (clr === 1'b1) clr_n++;
    if (dwr === 1'b1) dwr_n++;
    if (crd === 1'b1) crd_n++;
    if (drd === 1'b1) drd_n++;
    if (cwr === 1'b1 || dwr === 1'b1) cap_wd = fwd;
  end

  usb_fifo_port_config usb_fifo_port_config_inst (.clk(clk),
    .reset_n(reset_n), .sw_reset(sw_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pipe_empty_status(pes), .engine_busy(eb), .fifo_full(full),
    .cfifo_rdata(crdata), .dfifo_rdata(drdata), .fifo_wdata(fwd),
    .cfifo_wr(cwr), .cfifo_rd(crd), .dfifo_wr(dwr), .dfifo_rd(drd),
    .current_pipe(cur), .buffer_swap(swp), .engine_buffer_clear(clr),
    .big_endian(big), .data_pins_function_select(split),
    .output_drive_select(drv), .gp_port_pins_in(gp_in),
    .gp_port_pins_out(gp_out), .gp_port_pins_oe_n(oe_n),
    .buffer_empty_summary_flag(flag), .irq(irq));
  engine_model engine_model_inst (.clk(clk), .reset_n(reset_n),
    .busy_cmd(busy_cmd), .empty_cmd(empty_cmd), .full_cmd(full_cmd),
    .pipe_empty_status(pes), .engine_busy(eb), .fifo_full(full),
    .cfifo_rdata(crdata), .dfifo_rdata(drdata));

  // ===========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
      input logic [15:0] d, output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 16'h0000, r, e);
    chk(r, x);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ===========================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rdc(IDX_PIN_CFG, 32'h0);
    rdc(IDX_CPORT_CTRL, 32'h0);
    rdc(IDX_EMPTY_EN, 32'h0);
    // Reserved bits always written as zero
    wr(IDX_PIN_CFG, 16'h8105);
    wr(IDX_EMPTY_EN, 16'h007f);
    @(posedge clk) sw_reset <= 1'b1;
    @(posedge clk) sw_reset <= 1'b0;
    rdc(IDX_PIN_CFG, 32'h0);
    rdc(IDX_EMPTY_EN, 32'h0);
    apb(1'b0, 10'h3ff, 16'h0, r, e);
    chk({r[31:1], e}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_pins;
    wr(IDX_PIN_CFG, 16'h8105);
    rdc(IDX_PIN_CFG, 32'h8105);
    tick(1);
    chk({big, split, drv}, 32'h7);
    chk(oe_n, 32'hff);
    wr(IDX_PIN_CFG, 16'h0004);
    wr(IDX_GP_OUT, 16'h00a5);
    tick(1);
    chk({split, oe_n, gp_out}, 32'h00a5);
    wr(IDX_PIN_CFG, 16'h0000);
    rdc(IDX_GP_IN, 32'h5a);
    tick(1);
    chk(oe_n, 32'hff);
    $display("pin test done");
  endtask
  task automatic t_endian;
    int c0 = crd_n;
    wr(IDX_PIN_CFG, 16'h0100);
    rdc(IDX_CPORT_DATA, 32'h3412);
    wr(IDX_CPORT_DATA, 16'habcd);
    tick(2);
    chk(cap_wd, 32'hcdab);
    wr(IDX_PIN_CFG, 16'h0000);
    rdc(IDX_CPORT_DATA, 32'h1234);
    tick(1);
    chk(crd_n, c0 + 2);
    $display("byte order test done");
  endtask
  task automatic t_split;
    logic [31:0] r;
    logic e;
    int n0 = dwr_n;
    int m0 = drd_n;
    wr(IDX_PIN_CFG, 16'h0001);
    wr(IDX_DPORT_DATA, 16'h1111);
    apb(1'b0, IDX_DPORT_DATA, 16'h0, r, e);
    tick(2);
    chk({r[30:0], e}, 32'h0);
    chk(dwr_n, n0);
    chk(drd_n, m0);
    wr(IDX_PIN_CFG, 16'h0100);
    wr(IDX_DPORT_DATA, 16'h1234);
    rdc(IDX_DPORT_DATA, 32'h7856);
    tick(2);
    chk(cap_wd, 32'h3412);
    chk(dwr_n, n0 + 1);
    chk(drd_n, m0 + 1);
    wr(IDX_PIN_CFG, 16'h0000);
    $display("split bus test done");
  endtask
  task automatic t_swap;
    int n0 = swp_n;
    wr(IDX_PIPE_SEL, 16'h0001);
    wr(IDX_PIPE_DIR, 16'h0000);
    wr(IDX_PIPE_CONT, 16'h0002);
    wr(IDX_IRQ_MASK, 16'h0001);
    wr(IDX_CPORT_CTRL, 16'h8000);
    tick(3);
    chk(swp_n, n0 + 1);
    chk(irq, 1);
    rdc(IDX_IRQ_STATUS, 32'h1);
    rdc(IDX_CPORT_CTRL, 32'h0);
    wr(IDX_IRQ_STATUS, 16'h0001);
    wr(IDX_CPORT_CTRL, 16'h0000);
    full_cmd <= 1'b1;
    tick(2);
    wr(IDX_CPORT_CTRL, 16'h8000);
    full_cmd <= 1'b0;
    wr(IDX_PIPE_SEL, 16'h0000);
    wr(IDX_CPORT_CTRL, 16'h8000);
    tick(3);
    chk(cur, 32'h0);
    chk(swp_n, n0 + 1);
    chk(irq, 0);
    $display("swap test done");
  endtask
  task automatic t_clear;
    int n0 = clr_n;
    int s0 = swp_n;
    wr(IDX_PIPE_DIR, 16'h0003);
    // Clear first written with control pipe 0 selected, then with IN pipe 1
    wr(IDX_CPORT_CTRL, 16'h4000);
    tick(2);
    chk(clr_n, n0);
    wr(IDX_PIPE_SEL, 16'h0001);
    busy_cmd <= 7'h02;
    tick(2);
    chk(cur, 32'h1);
    rdc(IDX_CPORT_CTRL, 32'h2000);
    busy_cmd <= 7'h04;
    tick(2);
    // Busy polled low before the clear
    rdc(IDX_CPORT_CTRL, 32'h0);
    wr(IDX_CPORT_CTRL, 16'h4000);
    tick(3);
    chk(clr_n, n0 + 1);
    wr(IDX_PIPE_SEL, 16'h0002);
    wr(IDX_CPORT_CTRL, 16'h8000);
    tick(3);
    chk(swp_n, s0);
    @(posedge clk) busy_cmd <= 7'h00;
    $display("clear test done");
  endtask
  task automatic t_empty;
    wr(IDX_EMPTY_EN, 16'h007f);
    rdc(IDX_EMPTY_EN, 32'h7f);
    wr(IDX_EMPTY_EN, 16'h0040);
    wr(IDX_IRQ_MASK, 16'h0002);
    empty_cmd <= 7'h08;
    tick(4);
    chk({flag, irq}, 32'h0);
    wr(IDX_EMPTY_EN, 16'h0008);
    tick(3);
    chk({flag, irq}, 32'h3);
    @(posedge clk) empty_cmd <= 7'h00;
    tick(2);
    wr(IDX_IRQ_STATUS, 16'h0002);
    tick(2);
    chk({flag, irq}, 32'h0);
    $display("empty flag test done");
  endtask

  // ===========================================
  // Sequence and verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_pins;
    t_endian;
    t_split;
    t_swap;
    t_clear;
    t_empty;
    conclude;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    fail_count++;
    conclude;
  end
endmodule
